// File: keypad_cfg.svh
/*
 * Constants of the keypad result and event buffer block: register addresses,
 * field positions, reset values and serial framing counts.
 * Assumes it is included by bare name from every file that needs it.
 */
`ifndef KEYPAD_CFG_SVH
`define KEYPAD_CFG_SVH

// Register addresses on the serial register interface
`define ADDR_KEY_CODE_FIRST  8'h0B
`define ADDR_KEY_CODE_SECOND 8'h0C
`define ADDR_KEY_CODE_THIRD  8'h0D
`define ADDR_KEY_CODE_FOURTH 8'h0E
`define ADDR_KEY_EVENT_QUEUE 8'h10
`define ADDR_IRQ_CLEAR       8'h0A

// Values and field positions
`define KEY_CODE_RESET       8'h7F
`define EVENT_EMPTY_CODE     8'h7F
`define UNMAPPED_READ        8'h00
`define BIT_EVENT_CLEAR      1
`define BIT_SCAN_CLEAR       0
`define BIT_TX_MSB           7
`define BIT_RW               0

// Serial framing: data bits per byte
`define BITS_PER_BYTE        4'h8

`endif

// File: keypad_pkg.sv
/*
 * Types shared by the keypad result logic and its bench.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package keypad_pkg;

	// One key location as delivered by the scanner
	typedef struct packed {
		logic [2:0] key_row_index;     // Row 0..7
		logic [3:0] key_column_index;  // Column 0..11, 12 is special_function_key
	} key_slot_s;

	// Layout of a key code register
	typedef struct packed {
		logic       more_keys_flag;    // Another key follows, or overflow in last slot
		key_slot_s  slot;              // Row and column
	} key_code_s;

	// Layout of one key event entry
	typedef struct packed {
		logic       released;          // 0 pressed, 1 released
		key_slot_s  slot;              // Row and column
	} key_event_s;

	// Serial slave states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WRITE,
		ST_WRITE_ACK,
		ST_READ,
		ST_READ_ACK
	} serial_state_e;

endpackage

// File: event_skid.sv
/*
 * Two-entry buffer with valid and ready on both sides, placed between the
 * scanner's event strobe and the event queue so a stalled queue loses no word.
 * Assumes source and sink run on clk_sys; flush drops everything held.
 */
`timescale 1ns/10ps
`default_nettype none

module event_skid #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             flush,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	logic [WIDTH-1:0] mem_q [2];      // Two entries
	logic             wr_sel_q;       // Next entry to write
	logic             rd_sel_q;       // Next entry to read
	logic [1:0]       count_q;        // Entries held
	logic [1:0]       count_d;
	logic             push;
	logic             pop;

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_valid = (count_q != 2'h0);
	assign out_data  = mem_q[rd_sel_q];

	// Occupancy after this cycle
	always_comb begin
		count_d = count_q;
		if (flush) begin
			count_d = 2'h0;
		end else if (push && !pop) begin
			count_d = count_q + 2'h1;
		end else if (pop && !push) begin
			count_d = count_q - 2'h1;
		end
	end

	// Storage and pointers
	always_ff @(posedge clk_sys) begin
		if (rst || flush) begin
			wr_sel_q <= 1'b0;
			rd_sel_q <= 1'b0;
		end else begin
			if (push) begin
				mem_q[wr_sel_q] <= in_data;
				wr_sel_q        <= ~wr_sel_q;
			end
			if (pop) begin
				rd_sel_q <= ~rd_sel_q;
			end
		end
	end

	// Count and registered ready; ready reflects next cycle's room
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			count_q  <= 2'h0;
			in_ready <= 1'b0;
		end else begin
			count_q  <= count_d;
			in_ready <= (count_d != 2'h2);
		end
	end

endmodule // event_skid

`default_nettype wire

// File: keypad_result_and_event_fifo.sv
/*
 * Keypad result registers (four key code slots) and the key event queue,
 * read by a host over a two-wire serial slave sampled on clk_sys.
 * Assumes the scanner drives key slots and event pushes on clk_sys, and an
 * interrupt block elsewhere takes the clear pulses and the lost pulse.
 */
//
// Contract
// - Third key code readable at 0x0D
// - Third slot flag set when fourth valid
// - Fourth key code readable at 0x0E
// - Fourth slot flag means over four keys
// - Row in bits 6:4, resets to 7
// - Column in bits 3:0, resets to 15
// - Address 0x10 reads fifteen-deep event queue
// - Empty queue reads as 0x7F
// - No pointer increment on event queue
// - Event bit 7 press or release
// - Event row and column in low bits
// - Reading all four codes clears scan irq
// - No key reads first code 0x7F
// - Clear bit 1 flushes queue and event irq
// - First three slots chain more-keys flags
`timescale 1ns/10ps
`include "keypad_cfg.svh"
`default_nettype none

module keypad_result_and_event_fifo #(
	parameter int         DEPTH    = 15,      // Event queue entries
	parameter logic [6:0] DEV_ADDR = 7'h40    // Serial slave address, arbitrary value
) (
	// Clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	// Serial register interface pins
	input  wire logic                        scl_in,
	input  wire logic                        sda_in,
	output logic                             sda_out,
	output logic                             sda_oe,
	// Scanner key slots
	input  wire keypad_pkg::key_slot_s [3:0] key_slot,
	input  wire logic [3:0]                  key_valid,
	input  wire logic                        key_overflow,
	input  wire logic                        key_update,
	// Scanner events
	input  wire logic                        event_push_valid,
	input  wire keypad_pkg::key_event_s      event_push_data,
	output logic                             event_push_ready,
	// Interrupt block strobes
	output logic                             scan_irq_clear,
	output logic                             event_irq_clear,
	output logic                             event_lost
);

	// Pin synchronisers and edge history
	logic scl_meta_q, scl_sync_q, scl_prev_q;
	logic sda_meta_q, sda_sync_q, sda_prev_q;
	logic scl_rise, scl_fall, bus_start, bus_stop;

	// Serial slave state
	keypad_pkg::serial_state_e state_q;
	logic [3:0]  bit_cnt_q;            // Bits of current byte seen
	logic [7:0]  rx_q;                 // Received shift register
	logic [7:0]  tx_q;                 // Transmit shift register
	logic        rw_q;                 // 1 for a host read
	logic        nack_q;               // Host refused further bytes
	logic        first_byte_q;         // Next written byte is the pointer
	logic [7:0]  ptr_q;                // Register pointer

	// Strobes into the register side
	logic        rd_load;              // A byte is fetched for transmit
	logic        wr_commit;            // A written byte is complete
	logic [7:0]  rd_byte;              // Fetched byte

	// Key code registers and read tracking
	keypad_pkg::key_code_s [3:0] code_q;
	logic [3:0]  code_seen_q;          // Key code registers read since update

	// Event queue
	keypad_pkg::key_event_s    fifo_mem_q [DEPTH];
	logic [3:0]  fifo_wr_q;
	logic [3:0]  fifo_rd_q;
	logic [4:0]  fifo_cnt_q;
	logic        fifo_full;
	logic        fifo_empty;
	logic        fifo_push;
	logic        fifo_pop;
	logic        flush;
	keypad_pkg::key_event_s    skid_data;
	logic        skid_valid;

	// Edge and condition decode on synchronised pins only
	assign scl_rise  = scl_sync_q && !scl_prev_q;
	assign scl_fall  = !scl_sync_q && scl_prev_q;
	assign bus_start = scl_sync_q && scl_prev_q && !sda_sync_q && sda_prev_q;
	assign bus_stop  = scl_sync_q && scl_prev_q && sda_sync_q && !sda_prev_q;

	// Two flops before any logic, third for edges
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scl_meta_q <= 1'b1;
			scl_sync_q <= 1'b1;
			scl_prev_q <= 1'b1;
			sda_meta_q <= 1'b1;
			sda_sync_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_meta_q <= scl_in;
			scl_sync_q <= scl_meta_q;
			scl_prev_q <= scl_sync_q;
			sda_meta_q <= sda_in;
			sda_sync_q <= sda_meta_q;
			sda_prev_q <= sda_sync_q;
		end
	end

	// Fetch on the falling edge that opens a read byte
	assign rd_load   = scl_fall && !bus_start && !bus_stop &&
	                   ((state_q == keypad_pkg::ST_ADDR_ACK && rw_q) ||
	                    (state_q == keypad_pkg::ST_READ_ACK && !nack_q));
	assign wr_commit = scl_fall && !bus_start && !bus_stop &&
	                   state_q == keypad_pkg::ST_WRITE && bit_cnt_q == `BITS_PER_BYTE;

	// Read multiplexer
	always_comb begin
		rd_byte = `UNMAPPED_READ;
		case (ptr_q)
			`ADDR_KEY_CODE_FIRST:  rd_byte = code_q[0];
			`ADDR_KEY_CODE_THIRD:  rd_byte = code_q[2];
			`ADDR_KEY_CODE_SECOND: rd_byte = code_q[1];
			`ADDR_KEY_CODE_FOURTH: rd_byte = code_q[3];
			`ADDR_KEY_EVENT_QUEUE: begin
				rd_byte = fifo_empty ? `EVENT_EMPTY_CODE : fifo_mem_q[fifo_rd_q];
			end
			default:               rd_byte = `UNMAPPED_READ;
		endcase
	end

	// Serial slave sequencing and data line drive
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q      <= keypad_pkg::ST_IDLE;
			bit_cnt_q    <= 4'h0;
			rx_q         <= 8'h00;
			tx_q         <= 8'h00;
			rw_q         <= 1'b0;
			nack_q       <= 1'b0;
			first_byte_q <= 1'b0;
			sda_oe       <= 1'b0;
			sda_out      <= 1'b0;
		end else if (bus_stop) begin
			// Stop ends any transfer and frees the line
			state_q <= keypad_pkg::ST_IDLE;
			sda_oe  <= 1'b0;
		end else if (bus_start) begin
			// Start or repeated start: expect an address
			state_q   <= keypad_pkg::ST_ADDR;
			bit_cnt_q <= 4'h0;
			sda_oe    <= 1'b0;
		end else begin
			case (state_q)
				keypad_pkg::ST_ADDR: begin
					if (scl_rise) begin
						rx_q      <= {rx_q[6:0], sda_sync_q};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (scl_fall && bit_cnt_q == `BITS_PER_BYTE) begin
						if (rx_q[7:1] == DEV_ADDR) begin
							// Address match: acknowledge by pulling low
							state_q <= keypad_pkg::ST_ADDR_ACK;
							rw_q    <= rx_q[`BIT_RW];
							sda_oe  <= 1'b1;
						end else begin
							state_q <= keypad_pkg::ST_IDLE;
						end
					end
				end
				keypad_pkg::ST_ADDR_ACK: begin
					if (scl_fall) begin
						bit_cnt_q    <= 4'h0;
						first_byte_q <= 1'b1;
						if (rw_q) begin
							state_q <= keypad_pkg::ST_READ;
							tx_q    <= rd_byte;
							sda_oe  <= !rd_byte[`BIT_TX_MSB];
						end else begin
							state_q <= keypad_pkg::ST_WRITE;
							sda_oe  <= 1'b0;
						end
					end
				end
				keypad_pkg::ST_WRITE: begin
					if (scl_rise) begin
						rx_q      <= {rx_q[6:0], sda_sync_q};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (wr_commit) begin
						// Every written byte is acknowledged
						state_q      <= keypad_pkg::ST_WRITE_ACK;
						first_byte_q <= 1'b0;
						sda_oe       <= 1'b1;
					end
				end
				keypad_pkg::ST_WRITE_ACK: begin
					if (scl_fall) begin
						state_q   <= keypad_pkg::ST_WRITE;
						bit_cnt_q <= 4'h0;
						sda_oe    <= 1'b0;
					end
				end
				keypad_pkg::ST_READ: begin
					if (scl_rise) begin
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt_q == `BITS_PER_BYTE) begin
							// Release for the host's acknowledge
							state_q <= keypad_pkg::ST_READ_ACK;
							sda_oe  <= 1'b0;
						end else begin
							tx_q   <= {tx_q[6:0], 1'b0};
							sda_oe <= !tx_q[6];
						end
					end
				end
				keypad_pkg::ST_READ_ACK: begin
					if (scl_rise) begin
						nack_q <= sda_sync_q;
					end else if (scl_fall) begin
						if (nack_q) begin
							state_q <= keypad_pkg::ST_IDLE;
						end else begin
							state_q   <= keypad_pkg::ST_READ;
							bit_cnt_q <= 4'h0;
							tx_q      <= rd_byte;
							sda_oe    <= !rd_byte[`BIT_TX_MSB];
						end
					end
				end
				default: begin
					// Idle: wait for a start
					state_q <= keypad_pkg::ST_IDLE;
					sda_oe  <= 1'b0;
				end
			endcase
		end
	end

	// Register pointer: set by first written byte, steps after each access except while it holds the event queue address
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ptr_q <= 8'h00;
		end else if (wr_commit && first_byte_q) begin
			ptr_q <= rx_q;
		end else if ((wr_commit || rd_load) && ptr_q != `ADDR_KEY_EVENT_QUEUE) begin
			ptr_q <= ptr_q + 8'h01;
		end
	end

	// Key code slots, latched on the scanner's update strobe
	for (genvar i = 0; i < 4; i++) begin : g_slot
		logic more;
		// flag chains to the next slot
		if (i < 3) begin : g_chain
			assign more = key_valid[i+1];
		end else begin : g_last
			assign more = key_overflow;
		end
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				// row resets to 7, column resets to 15
				code_q[i] <= `KEY_CODE_RESET;
			end else if (key_update) begin
				code_q[i] <= key_valid[i] ? {more, key_slot[i]} : `KEY_CODE_RESET;
			end
		end
	end

	// track reads of all four codes
	always_ff @(posedge clk_sys) begin
		if (rst || key_update) begin
			code_seen_q <= 4'h0;
		end else if (code_seen_q == 4'hF) begin
			code_seen_q <= 4'h0;
		end else if (rd_load && ptr_q >= `ADDR_KEY_CODE_FIRST &&
		             ptr_q <= `ADDR_KEY_CODE_FOURTH) begin
			code_seen_q[ptr_q[1:0] - 2'h3] <= 1'b1;
		end
	end

	assign flush = wr_commit && !first_byte_q && ptr_q == `ADDR_IRQ_CLEAR &&
	               rx_q[`BIT_EVENT_CLEAR];

	// Clear pulses and lost strobe to the interrupt block
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scan_irq_clear  <= 1'b0;
			event_irq_clear <= 1'b0;
			event_lost      <= 1'b0;
		end else begin
			// all four read acts as scan clear
			scan_irq_clear  <= (code_seen_q == 4'hF) ||
			                   (wr_commit && !first_byte_q && ptr_q == `ADDR_IRQ_CLEAR &&
			                    rx_q[`BIT_SCAN_CLEAR]);
			event_irq_clear <= flush;
			// Push refused while the skid buffer is full
			event_lost      <= event_push_valid && !event_push_ready;
		end
	end

	// Skid buffer ahead of the queue; stalls when the queue is full
	event_skid #(
		.WIDTH($bits(keypad_pkg::key_event_s))
	) u_skid (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.flush    (flush),
		.in_valid (event_push_valid),
		.in_ready (event_push_ready),
		.in_data  (event_push_data),
		.out_valid(skid_valid),
		.out_ready(!fifo_full),
		.out_data (skid_data)
	);

	assign fifo_full  = (fifo_cnt_q == 5'(DEPTH));
	assign fifo_empty = (fifo_cnt_q == 5'h00);
	assign fifo_push  = skid_valid && !fifo_full;
	assign fifo_pop   = rd_load && ptr_q == `ADDR_KEY_EVENT_QUEUE && !fifo_empty;

	// Queue storage; kept by storing the event layout whole
	always_ff @(posedge clk_sys) begin
		if (fifo_push) begin
			fifo_mem_q[fifo_wr_q] <= skid_data;
		end
	end

	// Queue pointers and occupancy
	always_ff @(posedge clk_sys) begin
		if (rst || flush) begin
			fifo_wr_q  <= 4'h0;
			fifo_rd_q  <= 4'h0;
			fifo_cnt_q <= 5'h00;
		end else begin
			if (fifo_push) begin
				fifo_wr_q <= (fifo_wr_q == 4'(DEPTH - 1)) ? 4'h0 : fifo_wr_q + 4'h1;
			end
			if (fifo_pop) begin
				fifo_rd_q <= (fifo_rd_q == 4'(DEPTH - 1)) ? 4'h0 : fifo_rd_q + 4'h1;
			end
			if (fifo_push && !fifo_pop) begin
				fifo_cnt_q <= fifo_cnt_q + 5'h01;
			end else if (fifo_pop && !fifo_push) begin
				fifo_cnt_q <= fifo_cnt_q - 5'h01;
			end
		end
	end

endmodule // keypad_result_and_event_fifo

`default_nettype wire

// File: keypad_monitor.sv
/*
 Port checker for the keypad result block: event push handshake,
 clear strobes and the open-drain data pin.
 Assumes it is bound onto keypad_result_and_event_fifo.
*/
`timescale 1ns/10ps
`default_nettype none

module keypad_monitor (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Serial pins
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// Event push and strobes
	input wire logic event_push_valid,
	input wire logic event_push_ready,
	input wire logic scan_irq_clear,
	input wire logic event_irq_clear,
	input wire logic event_lost
);
	// One clock domain, reset is synchronous
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// Open drain: the pin may only be pulled low
	sink_only_a: assert property (sda_out == 1'b0)
		else $error("sda_out driven high");
	// Data may only move while the serial clock is low
	oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("sda_oe moved while scl high");
	// A lost event needs a refused push before it
	lost_cause_a: assert property (event_lost |-> $past(event_push_valid && !event_push_ready))
		else $error("event_lost without refusal");
	// Every refused push cycle is flagged
	lost_flag_a: assert property (event_push_valid && !event_push_ready |=> event_lost)
		else $error("refused push not flagged");
	// Empty buffer accepts right after reset
	ready_up_a: assert property ($fell(rst) |=> event_push_ready)
		else $error("not ready after reset");
	// Clear strobes are single pulses
	evclr_pulse_a: assert property (event_irq_clear |=> !event_irq_clear)
		else $error("event clear strobe too long");
	scclr_pulse_a: assert property (scan_irq_clear |=> !scan_irq_clear)
		else $error("scan clear strobe too long");
	// A flush leaves room for pushes
	flush_ready_a: assert property (event_irq_clear |-> ##[0:2] event_push_ready)
		else $error("not ready after flush");
endmodule // keypad_monitor

bind keypad_result_and_event_fifo keypad_monitor i_keypad_monitor (
	.clk_sys(clk_sys), .rst(rst), .scl_in(scl_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .event_push_valid(event_push_valid),
	.event_push_ready(event_push_ready), .scan_irq_clear(scan_irq_clear),
	.event_irq_clear(event_irq_clear), .event_lost(event_lost)
);

`default_nettype wire

// File: keypad_host.sv
/*
 Host side of the two-wire register link, driven by tasks.
 Assumes a pulled-up data line resolved by the bench.
*/
`timescale 1ns/10ps
`default_nettype none

module keypad_host (
	// Link pins as the host sees them
	output var logic scl,
	output var logic sda_low,
	input  wire logic sda
);
	// Quarter of the 125 ns bit time
	localparam realtime Q = 31.25;

	// Idle bus: clock high, data released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// One bit: set with clock low, sampled mid high phase
	task automatic bt(input logic b, output logic r);
		sda_low = !b;
		#Q scl = 1'b1;
		#Q r = sda;
		#Q scl = 1'b0;
		#Q;
	endtask

	// Start or repeated start; odd offset keeps edges off clk_sys
	task automatic sta();
		#1.3 sda_low = 1'b0;
		#Q scl = 1'b1;
		#Q sda_low = 1'b1;
		#Q scl = 1'b0;
		#Q;
	endtask

	// Stop: data rises while clock is high, then the clock stands
	task automatic sto();
		sda_low = 1'b1;
		#Q scl = 1'b1;
		#Q sda_low = 1'b0;
		#Q;
	endtask

	// Eight bits MSB first, then the acknowledge bit
	task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
		logic t;
		for (int i = 7; i >= 0; i--) begin
			bt(d[i], t);
			r[i] = t;
		end
		bt(a, k);
	endtask
endmodule // keypad_host

`default_nettype wire

// File: keypad_result_and_event_fifo_tb.sv
/*
 Bench for the keypad result block: key code slots, event queue
 and clear register, all reached over the two-wire link.
 Assumes keypad_host as link master and the bound checker.
*/
`timescale 1ns/10ps
`include "keypad_cfg.svh"
`default_nettype none

module keypad_result_and_event_fifo_tb;
	// Design pins
	logic                        clk_sys, rst, scl, host_low, key_overflow, key_update;
	wire                         sda_line;
	keypad_pkg::key_slot_s [3:0] key_slot;
	logic [3:0]                  key_valid;
	logic                        event_push_valid, event_push_ready, ok;
	keypad_pkg::key_event_s      event_push_data;
	logic                        sda_oe, scan_irq_clear, event_irq_clear, event_lost;
	// Bench state
	int                          n_errors, compares, cyc, n_scan, n_evclr, n_lost;
	logic [7:0]                  got [18];
	logic [7:0]                  ek [4];
	// Slave address, arbitrary value
	localparam logic [6:0]       DEV = 7'h40;

	// Pulled-up line, low when either side pulls
	assign sda_line = ~(host_low | sda_oe);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	keypad_result_and_event_fifo #(.DEPTH(15), .DEV_ADDR(DEV)) i_keypad_result_and_event_fifo (
		.clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda_line),
		.sda_out(), .sda_oe(sda_oe), .key_slot(key_slot), .key_valid(key_valid),
		.key_overflow(key_overflow), .key_update(key_update),
		.event_push_valid(event_push_valid), .event_push_data(event_push_data),
		.event_push_ready(event_push_ready), .scan_irq_clear(scan_irq_clear),
		.event_irq_clear(event_irq_clear), .event_lost(event_lost)
	);

	keypad_host i_keypad_host (.scl(scl), .sda_low(host_low), .sda(sda_line));

	// Strobe counters and hang guard
	always @(posedge clk_sys) begin
		cyc++;
		n_scan += scan_irq_clear;
		n_evclr += event_irq_clear;
		n_lost += event_lost;
		if (cyc == 20000) begin
			n_errors++;
			summarize();
		end
	end

	task automatic summarize();
		if (n_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask

	// Send one byte and expect the device to acknowledge it
	task automatic sb(input logic [7:0] b);
		logic [7:0] r;
		logic k;
		i_keypad_host.xb(b, 1'b1, r, k);
		chk({7'h00, k}, 8'h00);
	endtask

	// Burst read of n bytes from a pointer; last byte is not acknowledged
	task automatic rd(input logic [7:0] a, input int n);
		logic k;
		@(posedge clk_sys);
		i_keypad_host.sta();
		sb({DEV, 1'b0});
		sb(a);
		i_keypad_host.sta();
		sb({DEV, 1'b1});
		for (int i = 0; i < n; i++)
			i_keypad_host.xb(8'hFF, i == n - 1, got[i], k);
		i_keypad_host.sto();
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		i_keypad_host.sta();
		sb({DEV, 1'b0});
		sb(a);
		sb(d);
		i_keypad_host.sto();
	endtask

	// New scan result, latched by a one-cycle update pulse
	task automatic setkeys(input logic [3:0] v, input logic o);
		@(posedge clk_sys);
		key_valid <= v;
		key_overflow <= o;
		key_update <= 1'b1;
		@(posedge clk_sys);
		key_update <= 1'b0;
	endtask

	// Hold the push up to four edges; ok tells whether it was taken
	task automatic push(input logic [7:0] d);
		@(posedge clk_sys);
		event_push_valid <= 1'b1;
		event_push_data <= keypad_pkg::key_event_s'(d);
		ok = 1'b0;
		for (int w = 0; w < 4 && !ok; w++) begin
			@(posedge clk_sys);
			ok = event_push_ready;
		end
		event_push_valid <= 1'b0;
	endtask

	// Event pattern: release bit, row, column up to 12
	function automatic logic [7:0] ev(input int i);
		return {i[0], i[2:0], 4'(i % 13)};
	endfunction

	initial begin
		rst = 1'b1;
		key_slot = {7'h29, 7'h5C, 7'h7B, 7'h00};
		key_valid = 4'h0;
		key_overflow = 1'b0;
		key_update = 1'b0;
		event_push_valid = 1'b0;
		event_push_data = 8'h00;
		ek = '{8'h80, 8'hFB, 8'hDC, 8'hA9};
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		// Reset values, empty queue, unmapped place
		rd(`ADDR_KEY_CODE_FIRST, 4);
		for (int i = 0; i < 4; i++) chk(got[i], `KEY_CODE_RESET);
		chk(8'(n_scan), 8'h01);
		rd(`ADDR_KEY_EVENT_QUEUE, 1);
		chk(got[0], `EVENT_EMPTY_CODE);
		rd(8'h20, 1);
		chk(got[0], `UNMAPPED_READ);
		// Four keys plus overflow in one burst
		setkeys(4'hF, 1'b1);
		rd(`ADDR_KEY_CODE_FIRST, 4);
		for (int i = 0; i < 4; i++) chk(got[i], ek[i]);
		chk(8'(n_scan), 8'h02);
		// Three keys: no chain from third, fourth slot empty
		setkeys(4'h7, 1'b0);
		rd(`ADDR_KEY_CODE_THIRD, 2);
		chk(got[0], 8'h5C);
		chk(got[1], `KEY_CODE_RESET);
		chk(8'(n_scan), 8'h02);
		// Fill queue and skid until refused
		for (int i = 0; i < 18; i++) begin
			push(ev(i));
			chk({7'h00, ok}, {7'h00, i < 17});
		end
		repeat (2) @(posedge clk_sys);
		chk(8'(n_lost), 8'h04);
		// One burst drains oldest first, then shows empty
		rd(`ADDR_KEY_EVENT_QUEUE, 18);
		for (int i = 0; i < 17; i++) chk(got[i], ev(i));
		chk(got[17], `EVENT_EMPTY_CODE);
		// Clear bit empties a part-filled queue
		for (int i = 0; i < 3; i++) push(ev(i));
		wr(`ADDR_IRQ_CLEAR, 8'h02);
		chk(8'(n_evclr), 8'h01);
		rd(`ADDR_KEY_EVENT_QUEUE, 1);
		chk(got[0], `EVENT_EMPTY_CODE);
		summarize();
	end
endmodule // keypad_result_and_event_fifo_tb

`default_nettype wire
